// File: bench/emsbh_checker.sv
`timescale 1ns/100ps
`default_nettype none
module emsbh_chk (
  input wire MCLK_I,
  input wire RSTN_I,
  input wire PROCESSOR_CLOCK_OUT_O,
  input wire [13:0] ADDR_O,
  input wire [4:0] MEMORY_SPACE_SELECTS_N_O,
  input wire RD_N_O,
  input wire WR_N_O,
  input wire CTRL_OE_N_O,
  input wire DATA_OE_N_O,
  input wire BUS_GRANT_OUT_N_O,
  input wire GRANT_HUNG_N_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_float_first: assert property ($fell(BUS_GRANT_OUT_N_O) |->
    $past(CTRL_OE_N_O) && RD_N_O && WR_N_O) else $error("grant before float");
  chk_grant_rise: assert property ($rose(BUS_GRANT_OUT_N_O) |->
    CTRL_OE_N_O ##1 !CTRL_OE_N_O) else $error("retake order");
  chk_hung_float: assert property (!GRANT_HUNG_N_O |-> CTRL_OE_N_O)
    else $error("hung while driving");
  chk_strobe_phase: assert property ($fell(RD_N_O && WR_N_O) |->
    $past(PROCESSOR_CLOCK_OUT_O) && !$past(PROCESSOR_CLOCK_OUT_O, 2)) else $error("phase");
  chk_addr_steady: assert property ($fell(RD_N_O && WR_N_O) |->
    $stable(ADDR_O) && $stable(MEMORY_SPACE_SELECTS_N_O)) else $error("address moved");
  chk_data_span: assert property ($fell(DATA_OE_N_O) || !WR_N_O |->
    !DATA_OE_N_O && !WR_N_O) else $error("write data span");
  chk_data_hold: assert property ($rose(WR_N_O) |-> !DATA_OE_N_O ##1 DATA_OE_N_O)
    else $error("write data hold");
  chk_strobe_gap: assert property ($rose(WR_N_O) |=> RD_N_O && WR_N_O)
    else $error("strobe gap");
endmodule // emsbh_chk
bind emsbh_ctrl emsbh_chk u_chk (.*);
`default_nettype wire

// File: bench/emsbh_mem.sv
`timescale 1ns/100ps
`default_nettype none
module emsbh_mem (
  input wire logic clk_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [13:0] addr_i,
  input wire logic [23:0] data_i,
  input wire logic [4:0] lag_i,
  output logic [23:0] data_o
);
  logic [23:0] mem [0:16383];
  logic [23:0] last = 24'h0;
  logic wr_q = 1'b1;
  int n = 0;
  always @(posedge clk_i) begin
    wr_q <= wr_n_i;
    n <= rd_n_i ? 0 : n + 1;
    if (wr_n_i && !wr_q) mem[addr_i] <= data_i;
    last <= data_o;
  end
  // Word shows only after the lag; otherwise a pattern that flips every cycle
  assign data_o = (!rd_n_i && n >= lag_i) ? mem[addr_i] : ~last;
endmodule // emsbh_mem
`default_nettype wire

// File: bench/emsbh_test.sv
`timescale 1ns/100ps
`default_nettype none
module emsbh_test;
  logic MCLK_I = 0, RSTN_I = 0, ACC_REQ_I = 0, ACC_WRITE_I = 0, CORE_NEED_BUS_I = 0;
  logic EXT_BUS_REQUEST_N_I = 1;
  logic [2:0] ACC_SPACE_I = 0, ACC_WAIT_I = 0;
  logic [13:0] ACC_ADDR_I = 0, a;
  logic [23:0] ACC_WDATA_I = 0, d, ref_m [0:16383];
  logic [4:0] lag = 1;
  int errors = 0, num_checks = 0, cyc = 0, i, t, n;
  wire ACC_ACK_O, ACC_WR_DONE_O, RD_VALID_O, PROCESSOR_CLOCK_OUT_O, RD_N_O, WR_N_O;
  wire CTRL_OE_N_O, DATA_OE_N_O, BUS_GRANT_OUT_N_O, GRANT_HUNG_N_O;
  wire [4:0] MEMORY_SPACE_SELECTS_N_O;
  wire [13:0] ADDR_O;
  wire [23:0] RD_DATA_O, DATA_I, DATA_O;
  always #20 MCLK_I = ~MCLK_I;
  emsbh_ctrl DUT (.*);
  emsbh_mem u_mem (.clk_i(MCLK_I), .rd_n_i(RD_N_O), .wr_n_i(WR_N_O), .addr_i(ADDR_O),
    .data_i(DATA_O), .lag_i(lag), .data_o(DATA_I));
  task chk(input string nm, input logic [23:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task acc(input logic w, input logic [2:0] s, input logic [2:0] ws);
    @(negedge MCLK_I);
    {ACC_REQ_I, ACC_WRITE_I, ACC_SPACE_I} = {1'b1, w, s};
    {ACC_ADDR_I, ACC_WDATA_I, ACC_WAIT_I} = {a, d, ws};
    // Odd spaces get a memory that answers as late as the strobe allows
    lag = s[0] ? 5'h01 + 5'h04 * ws : 5'h01;
    for (t = 0; ACC_ACK_O !== 1'b1 && t < 40; t++) @(negedge MCLK_I);
    ACC_REQ_I = 0;
    chk("ack", 1, ACC_ACK_O);
    chk("addr", a, ADDR_O);
    chk("sel", s < 5 ? 5'(~(5'h01 << s)) : 5'h1F, MEMORY_SPACE_SELECTS_N_O);
    @(negedge MCLK_I);
    for (n = 0; (w ? WR_N_O : RD_N_O) === 1'b0 && n < 40; n++) @(negedge MCLK_I);
    chk("width", 24'(2 + 4 * ws), 24'(n));
    if (w) begin
      chk("done", 1, ACC_WR_DONE_O);
      ref_m[a] = d;
    end else begin
      for (t = 0; RD_VALID_O !== 1'b1 && t < 4; t++) @(negedge MCLK_I);
      chk("valid", 1, RD_VALID_O);
      chk("rdata", ref_m[a], RD_DATA_O);
    end
  endtask
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    i = $urandom(41602);
    repeat (2) @(negedge MCLK_I);
    RSTN_I = 1;
    for (i = 0; i < 6; i++) begin
      a = 14'($urandom);
      d = 24'($urandom);
      acc(1'b1, 3'(i), 3'($urandom));
      acc(1'b0, 3'(i), 3'($urandom));
    end
    fork
      acc(1'b0, 3'h1, 3'h2);
      begin
        @(posedge ACC_ACK_O);
        @(negedge MCLK_I);
        EXT_BUS_REQUEST_N_I = 0;
      end
    join
    for (t = 0; BUS_GRANT_OUT_N_O !== 1'b0 && t < 20; t++) @(negedge MCLK_I);
    chk("grant", 0, BUS_GRANT_OUT_N_O);
    chk("float", 3'h7, {CTRL_OE_N_O, RD_N_O, WR_N_O});
    chk("hung idle", 1, GRANT_HUNG_N_O);
    CORE_NEED_BUS_I = 1;
    @(negedge MCLK_I);
    chk("hung", 0, GRANT_HUNG_N_O);
    EXT_BUS_REQUEST_N_I = 1;
    CORE_NEED_BUS_I = 0;
    for (t = 0; BUS_GRANT_OUT_N_O !== 1'b1 && t < 20; t++) @(negedge MCLK_I);
    chk("regrant", 1, BUS_GRANT_OUT_N_O);
    chk("retake", 1, CTRL_OE_N_O);
    acc(1'b1, 3'h2, 3'h0);
    stop_test;
  end
endmodule // emsbh_test
`default_nettype wire

// File: hdl/emsbh_ctrl.v
// Notes on behaviour
// - Bus request is synchronised, acted on next boundary with no strobe low
// - Float selects and strobes before grant goes low
// - Raise grant first, then drive selects and strobes
// - Hung output low when core needs granted bus
// - Read strobe falls one quarter after clock rise
// - Address and select stable one quarter before strobe
// - Write data driven for whole write strobe
// - Write data held one quarter after strobe rise
// - Write data enabled only with strobe fall
// - Half cycle gap after strobe rise
// - Write strobe falls one quarter after clock rise
`timescale 1ns/100ps
`default_nettype none
`include "emsbh_map.vh"

module emsbh_ctrl #(
  parameter ADDR_W = 14,
  parameter DATA_W = 24,
  parameter WAIT_W = 3
) (
  input wire MCLK_I,
  input wire RSTN_I,
  input wire ACC_REQ_I,
  input wire ACC_WRITE_I,
  input wire [`EMSBH_SPACE_W-1:0] ACC_SPACE_I,
  input wire [ADDR_W-1:0] ACC_ADDR_I,
  input wire [DATA_W-1:0] ACC_WDATA_I,
  input wire [WAIT_W-1:0] ACC_WAIT_I,
  input wire CORE_NEED_BUS_I,
  output reg ACC_ACK_O,
  output reg ACC_WR_DONE_O,
  output reg RD_VALID_O,
  output reg [DATA_W-1:0] RD_DATA_O,
  output reg PROCESSOR_CLOCK_OUT_O,
  output reg [ADDR_W-1:0] ADDR_O,
  output reg [4:0] MEMORY_SPACE_SELECTS_N_O,
  output reg RD_N_O,
  output reg WR_N_O,
  output reg CTRL_OE_N_O,
  input wire [DATA_W-1:0] DATA_I,
  output reg [DATA_W-1:0] DATA_O,
  output reg DATA_OE_N_O,
  input wire EXT_BUS_REQUEST_N_I,
  output reg BUS_GRANT_OUT_N_O,
  output reg GRANT_HUNG_N_O
);

  reg [`EMSBH_PH_W-1:0] phase_q;
  reg [`EMSBH_ST_W-1:0] state_q;
  reg [`EMSBH_ST_W-1:0] state_d;
  reg [7:0] count_q;
  reg write_q;
  reg br_meta_q;
  reg br_sync_q;
  reg [DATA_W-1:0] din_meta_q;
  reg [DATA_W-1:0] din_sync_q;
  reg [1:0] rd_pipe_q;
  reg [4:0] sel_dec;
  wire boundary;
  wire bus_req;
  wire take_req;
  wire strobe_end;

  assign boundary = (phase_q == `EMSBH_PH_LAST);
  assign bus_req = br_sync_q;
  assign take_req = ACC_REQ_I && boundary && !bus_req;
  assign strobe_end = (count_q == 8'h01);

  always @* begin
    sel_dec = `EMSBH_SEL_NONE;
    case (ACC_SPACE_I)
      `EMSBH_SPACE_PROGRAM: sel_dec[`EMSBH_SEL_PROGRAM] = 1'b0;
      `EMSBH_SPACE_DATA: sel_dec[`EMSBH_SEL_DATA] = 1'b0;
      `EMSBH_SPACE_COMPOSITE: sel_dec[`EMSBH_SEL_COMPOSITE] = 1'b0;
      `EMSBH_SPACE_IO: sel_dec[`EMSBH_SEL_IO] = 1'b0;
      `EMSBH_SPACE_BYTE: sel_dec[`EMSBH_SEL_BYTE] = 1'b0;
      default: sel_dec = `EMSBH_SEL_NONE;
    endcase
  end

  // Two-stage synchronisers for the request pin and the data bus
  always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      br_meta_q <= 1'b0;
      br_sync_q <= 1'b0;
      din_meta_q <= {DATA_W{1'b0}};
      din_sync_q <= {DATA_W{1'b0}};
    end else begin
      br_meta_q <= ~EXT_BUS_REQUEST_N_I;
      br_sync_q <= br_meta_q;
      din_meta_q <= DATA_I;
      din_sync_q <= din_meta_q;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      `EMSBH_ST_IDLE, `EMSBH_ST_HOLD: begin
        if (boundary && bus_req) begin
          state_d = `EMSBH_ST_RELEASE;
        end else if (take_req) begin
          state_d = `EMSBH_ST_SETUP;
        end else if (state_q == `EMSBH_ST_HOLD) begin
          state_d = `EMSBH_ST_IDLE;
        end
      end
      `EMSBH_ST_SETUP: state_d = `EMSBH_ST_STROBE;
      `EMSBH_ST_STROBE: begin
        if (strobe_end) begin
          state_d = `EMSBH_ST_HOLD;
        end
      end
      `EMSBH_ST_RELEASE: state_d = `EMSBH_ST_GRANTED;
      `EMSBH_ST_GRANTED: begin
        if (!bus_req) begin
          state_d = `EMSBH_ST_RETAKE;
        end
      end
      `EMSBH_ST_RETAKE: state_d = `EMSBH_ST_IDLE;
      default: state_d = `EMSBH_ST_IDLE;
    endcase
  end

  always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      phase_q <= `EMSBH_PH_LAST;
      state_q <= `EMSBH_ST_IDLE;
      count_q <= 8'h00;
      write_q <= 1'b0;
      rd_pipe_q <= 2'b00;
      ACC_ACK_O <= 1'b0;
      ACC_WR_DONE_O <= 1'b0;
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= {DATA_W{1'b0}};
      PROCESSOR_CLOCK_OUT_O <= 1'b0;
      ADDR_O <= {ADDR_W{1'b0}};
      MEMORY_SPACE_SELECTS_N_O <= `EMSBH_SEL_NONE;
      RD_N_O <= 1'b1;
      WR_N_O <= 1'b1;
      CTRL_OE_N_O <= 1'b0;
      DATA_O <= {DATA_W{1'b0}};
      DATA_OE_N_O <= 1'b1;
      BUS_GRANT_OUT_N_O <= 1'b1;
      GRANT_HUNG_N_O <= 1'b1;
    end else begin
      phase_q <= phase_q + 2'h1;
      // Output clock high for the first two quarters of each cycle
      PROCESSOR_CLOCK_OUT_O <= (phase_q == `EMSBH_PH_LAST) || (phase_q == `EMSBH_PH_RISE);
      state_q <= state_d;
      ACC_ACK_O <= 1'b0;
      ACC_WR_DONE_O <= 1'b0;
      RD_VALID_O <= 1'b0;
      rd_pipe_q <= {rd_pipe_q[0], 1'b0};
      if (rd_pipe_q[1]) begin
        RD_VALID_O <= 1'b1;
        RD_DATA_O <= din_sync_q;
      end
      case (state_d)
        `EMSBH_ST_SETUP: begin
          if (state_q != `EMSBH_ST_SETUP) begin
            ACC_ACK_O <= 1'b1;
            write_q <= ACC_WRITE_I;
            // Address and select lead the strobe by one quarter
            ADDR_O <= ACC_ADDR_I;
            MEMORY_SPACE_SELECTS_N_O <= sel_dec;
            DATA_O <= ACC_WDATA_I;
            count_q <= `EMSBH_STROBE_BASE + ({{(8-WAIT_W){1'b0}}, ACC_WAIT_I}
              * `EMSBH_QUARTERS_PER_CYCLE);
          end
          DATA_OE_N_O <= 1'b1;
        end
        `EMSBH_ST_STROBE: begin
          if (state_q == `EMSBH_ST_SETUP) begin
            RD_N_O <= write_q;
            WR_N_O <= ~write_q;
            DATA_OE_N_O <= ~write_q;
          end else begin
            count_q <= count_q - 8'h01;
          end
        end
        `EMSBH_ST_HOLD: begin
          if (state_q == `EMSBH_ST_STROBE) begin
            RD_N_O <= 1'b1;
            WR_N_O <= 1'b1;
            ACC_WR_DONE_O <= write_q;
            rd_pipe_q <= {rd_pipe_q[0], ~write_q};
          end
        end
        `EMSBH_ST_IDLE: begin
          DATA_OE_N_O <= 1'b1;
          if (state_q == `EMSBH_ST_RETAKE) begin
            CTRL_OE_N_O <= 1'b0;
          end
        end
        `EMSBH_ST_RELEASE: begin
          DATA_OE_N_O <= 1'b1;
          CTRL_OE_N_O <= 1'b1;
          MEMORY_SPACE_SELECTS_N_O <= `EMSBH_SEL_NONE;
        end
        `EMSBH_ST_GRANTED: begin
          BUS_GRANT_OUT_N_O <= 1'b0;
          GRANT_HUNG_N_O <= ~(ACC_REQ_I | CORE_NEED_BUS_I);
        end
        `EMSBH_ST_RETAKE: begin
          BUS_GRANT_OUT_N_O <= 1'b1;
          GRANT_HUNG_N_O <= 1'b1;
        end
        default: begin
          DATA_OE_N_O <= 1'b1;
        end
      endcase
      // Back-to-back: next strobe cannot fall before two quarters after rise
      if (state_q == `EMSBH_ST_HOLD && state_d != `EMSBH_ST_HOLD) begin
        DATA_OE_N_O <= 1'b1;
      end
    end
  end

endmodule // emsbh_ctrl

`default_nettype wire

// File: hdl/emsbh_map.vh
`ifndef EMSBH_MAP_VH
`define EMSBH_MAP_VH

// Quarter phases of one processor cycle, one system clock each
`define EMSBH_PH_W 2
`define EMSBH_PH_RISE 2'h0
`define EMSBH_PH_STROBE 2'h1
`define EMSBH_PH_LAST 2'h3
`define EMSBH_QUARTERS_PER_CYCLE 8'h04
// Strobe stays low two quarters plus four per wait state
`define EMSBH_STROBE_BASE 8'h02

// Sequencer states
`define EMSBH_ST_W 3
`define EMSBH_ST_IDLE 3'h0
`define EMSBH_ST_SETUP 3'h1
`define EMSBH_ST_STROBE 3'h2
`define EMSBH_ST_HOLD 3'h3
`define EMSBH_ST_RELEASE 3'h4
`define EMSBH_ST_GRANTED 3'h5
`define EMSBH_ST_RETAKE 3'h6

// Memory space codes on the request port
`define EMSBH_SPACE_W 3
`define EMSBH_SPACE_PROGRAM 3'h0
`define EMSBH_SPACE_DATA 3'h1
`define EMSBH_SPACE_COMPOSITE 3'h2
`define EMSBH_SPACE_IO 3'h3
`define EMSBH_SPACE_BYTE 3'h4

// Select vector bit positions
`define EMSBH_SEL_PROGRAM 0
`define EMSBH_SEL_DATA 1
`define EMSBH_SEL_COMPOSITE 2
`define EMSBH_SEL_IO 3
`define EMSBH_SEL_BYTE 4
`define EMSBH_SEL_NONE 5'h1F

`endif
